// file: rtl/tls_top.sv
// torque limit select: apb registers, terminal routing, limit clipping, encoder mode
// assumes synchronous terminal inputs and one torque demand per clock
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "tls_map.svh"
module tls_top #(
    parameter int N_IN  = 8,
    parameter int N_OUT = 4
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                sys_rst,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic [31:0]              prdata,
    // terminals
    input  wire logic [N_IN-1:0]     in_term,
    output logic [N_OUT-1:0]         out_term,
    // torque path
    input  wire logic signed [11:0]  torque_ref,
    input  wire tls_pkg::tls_pct_t   motor_max,
    output logic signed [11:0]       torque_out,
    output logic                     torque_limited_flag,
    // encoder
    input  wire logic [15:0]         encoder_usage_select,
    input  wire logic [1:0]          enc_fitted,
    input  wire logic [31:0]         enc_abs_position,
    input  wire logic signed [7:0]   enc_delta,
    output logic [31:0]              position,
    output tls_pkg::tls_enc_mode_t   enc_mode,
    // interrupt
    output logic                     irq
);
    tls_pkg::tls_pct_t             fwd_internal_limit_reg;
    tls_pkg::tls_pct_t             rev_internal_limit_reg;
    tls_pkg::tls_pct_t             fwd_external_limit_reg;
    tls_pkg::tls_pct_t             rev_external_limit_reg;
    logic [15:0]                   limit_input_assign_reg;
    logic [15:0]                   limit_output_assign_reg;
    logic                          rev_ext_sel_reg;
    logic [`TLS_IRQ_W-1:0]         int_stat_reg;
    logic [`TLS_IRQ_W-1:0]         int_stat_next;
    logic [`TLS_IRQ_W-1:0]         int_mask_reg;
    logic [`TLS_IRQ_W-1:0]         events;
    logic [31:0]                   prdata_reg;
    logic [31:0]                   rdata;
    logic                          fwd_ext_limit_req;
    logic                          rev_ext_limit_req;
    logic                          fwd_req_reg;
    logic                          rev_req_reg;
    logic                          flag_reg;
    logic signed [11:0]            torque_out_reg;
    logic [N_OUT-1:0]              out_term_reg;
    logic [N_OUT-1:0]              out_term_next;
    logic                          started_reg;
    tls_pkg::tls_enc_mode_t        enc_mode_reg;
    tls_pkg::tls_enc_mode_t        enc_mode_next;
    logic [31:0]                   position_reg;
    tls_pkg::tls_limit_cfg_t       fwd_cfg;
    tls_pkg::tls_limit_cfg_t       rev_cfg;
    tls_pkg::tls_pct_t             fwd_limit;
    tls_pkg::tls_pct_t             rev_limit;
    logic                          fwd_limited;
    logic                          rev_limited;
    logic                          negative;
    logic [10:0]                   magnitude;
    logic [10:0]                   fwd_demand;
    logic [10:0]                   rev_demand;
    logic                          limited_now;
    logic signed [11:0]            torque_next;
    logic [3:0]                    enc_digit;
    logic                          wr_en;
    logic                          rd_setup;
    logic                          mapped;

    // apb decode; zero wait states, slverr on unmapped
    assign wr_en    = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped   = (paddr == `TLS_OFS_FWD_INT)   || (paddr == `TLS_OFS_REV_INT)
                   || (paddr == `TLS_OFS_FWD_EXT)   || (paddr == `TLS_OFS_REV_EXT)
                   || (paddr == `TLS_OFS_IN_ASSIGN) || (paddr == `TLS_OFS_OUT_ASSIGN)
                   || (paddr == `TLS_OFS_CTRL)      || (paddr == `TLS_OFS_STATUS)
                   || (paddr == `TLS_OFS_INT_STAT)  || (paddr == `TLS_OFS_INT_MASK)
                   || (paddr == `TLS_OFS_FWD_ACT)   || (paddr == `TLS_OFS_REV_ACT)
                   || (paddr == `TLS_OFS_POSITION);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_reg;

    always_comb begin
        unique case (paddr)
            `TLS_OFS_FWD_INT:    rdata = {22'h00_0000, fwd_internal_limit_reg};
            `TLS_OFS_REV_INT:    rdata = {22'h00_0000, rev_internal_limit_reg};
            `TLS_OFS_FWD_EXT:    rdata = {22'h00_0000, fwd_external_limit_reg};
            `TLS_OFS_REV_EXT:    rdata = {22'h00_0000, rev_external_limit_reg};
            `TLS_OFS_IN_ASSIGN:  rdata = {16'h0000, limit_input_assign_reg};
            `TLS_OFS_OUT_ASSIGN: rdata = {16'h0000, limit_output_assign_reg};
            `TLS_OFS_CTRL:       rdata = {31'h0000_0000, rev_ext_sel_reg};
            `TLS_OFS_STATUS:     rdata = {26'h000_0000, enc_mode_reg, started_reg,
                                          flag_reg, rev_req_reg, fwd_req_reg};
            `TLS_OFS_INT_STAT:   rdata = {29'h0000_0000, int_stat_reg};
            `TLS_OFS_INT_MASK:   rdata = {29'h0000_0000, int_mask_reg};
            `TLS_OFS_FWD_ACT:    rdata = {22'h00_0000, fwd_limit};
            `TLS_OFS_REV_ACT:    rdata = {22'h00_0000, rev_limit};
            `TLS_OFS_POSITION:   rdata = position_reg;
            default:             rdata = 32'h0000_0000;
        endcase
    end

    // RQ5 one percent per lsb
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fwd_internal_limit_reg <= `TLS_RST_INT_LIMIT;
            rev_internal_limit_reg <= `TLS_RST_INT_LIMIT;
            fwd_external_limit_reg <= `TLS_RST_EXT_LIMIT;
            rev_external_limit_reg <= `TLS_RST_EXT_LIMIT;
        end else if (wr_en) begin
            if (paddr == `TLS_OFS_FWD_INT) fwd_internal_limit_reg <= pwdata[9:0];
            if (paddr == `TLS_OFS_REV_INT) rev_internal_limit_reg <= pwdata[9:0];
            if (paddr == `TLS_OFS_FWD_EXT) fwd_external_limit_reg <= pwdata[9:0];
            if (paddr == `TLS_OFS_REV_EXT) rev_external_limit_reg <= pwdata[9:0];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            limit_input_assign_reg  <= `TLS_RST_IN_ASSIGN;
            limit_output_assign_reg <= `TLS_RST_OUT_ASSIGN;
            rev_ext_sel_reg         <= 1'b0;
            int_mask_reg            <= '0;
        end else if (wr_en) begin
            if (paddr == `TLS_OFS_IN_ASSIGN)  limit_input_assign_reg  <= pwdata[15:0];
            if (paddr == `TLS_OFS_OUT_ASSIGN) limit_output_assign_reg <= pwdata[15:0];
            if (paddr == `TLS_OFS_CTRL)       rev_ext_sel_reg         <= pwdata[`TLS_CTRL_REV_EXT];
            if (paddr == `TLS_OFS_INT_MASK)   int_mask_reg            <= pwdata[`TLS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_reg <= rdata;
        end
    end

    // RQ7 request terminal routing
    tls_term_sel #(.N_TERM(N_IN)) u_fwd_sel (
        .term  (in_term),
        .digit (limit_input_assign_reg[`TLS_FWD_DIGIT_LSB +: 4]),
        .level (fwd_ext_limit_req)
    );
    tls_term_sel #(.N_TERM(N_IN)) u_rev_sel (
        .term  (in_term),
        .digit (limit_input_assign_reg[`TLS_REV_DIGIT_LSB +: 4]),
        .level (rev_ext_limit_req)
    );

    // demand split by sign; the idle direction sees zero
    assign negative   = torque_ref[11];
    assign magnitude  = negative ? 11'(-torque_ref) : torque_ref[10:0];
    assign fwd_demand = negative ? 11'h000 : magnitude;
    assign rev_demand = negative ? magnitude : 11'h000;

    // RQ1 RQ2 forward pair
    assign fwd_cfg.internal = fwd_internal_limit_reg;
    assign fwd_cfg.external = fwd_external_limit_reg;
    // RQ3 RQ4 reverse pair, forward external by default as printed
    assign rev_cfg.internal = rev_internal_limit_reg;
    assign rev_cfg.external = rev_ext_sel_reg ? rev_external_limit_reg : fwd_external_limit_reg;

    tls_limit_calc u_fwd_calc (
        .cfg       (fwd_cfg),
        .motor_max (motor_max),
        .ext_req   (fwd_ext_limit_req),
        .demand    (fwd_demand),
        .limit     (fwd_limit),
        .limited   (fwd_limited)
    );
    tls_limit_calc u_rev_calc (
        .cfg       (rev_cfg),
        .motor_max (motor_max),
        .ext_req   (rev_ext_limit_req),
        .demand    (rev_demand),
        .limit     (rev_limit),
        .limited   (rev_limited)
    );

    // RQ11 clip to selected limit
    assign limited_now = fwd_limited || rev_limited;
    assign torque_next = fwd_limited ? $signed({2'b00, fwd_limit})
                       : rev_limited ? -$signed({2'b00, rev_limit})
                       : torque_ref;

    // RQ8 flag onto chosen terminal
    for (genvar i = 0; i < N_OUT; i++) begin : g_out
        assign out_term_next[i] = limited_now
                               && (limit_output_assign_reg[`TLS_OUT_DIGIT_LSB +: 4] == 4'(i));
    end

    // RQ12 registered each cycle, no restart needed
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            torque_out_reg <= 12'h000;
            flag_reg       <= 1'b0;
            out_term_reg   <= '0;
            fwd_req_reg    <= 1'b0;
            rev_req_reg    <= 1'b0;
        end else begin
            torque_out_reg <= torque_next;
            // RQ6 flag tracks limiting
            flag_reg       <= limited_now;
            out_term_reg   <= out_term_next;
            fwd_req_reg    <= fwd_ext_limit_req;
            rev_req_reg    <= rev_ext_limit_req;
        end
    end
    assign torque_out          = torque_out_reg;
    assign torque_limited_flag = flag_reg;
    assign out_term            = out_term_reg;

    // sticky events; a new event beats a same-cycle clear
    assign events[`TLS_IRQ_LIMITED] = limited_now && !flag_reg;
    assign events[`TLS_IRQ_FWD_REQ] = fwd_ext_limit_req != fwd_req_reg;
    assign events[`TLS_IRQ_REV_REQ] = rev_ext_limit_req != rev_req_reg;
    assign int_stat_next = (int_stat_reg & ~((wr_en && paddr == `TLS_OFS_INT_STAT)
                                             ? pwdata[`TLS_IRQ_W-1:0] : '0)) | events;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            int_stat_reg <= '0;
        end else begin
            int_stat_reg <= int_stat_next;
        end
    end
    assign irq = |(int_stat_reg & int_mask_reg);

    // RQ9 mode caught once after reset release; later digit changes wait for restart
    assign enc_digit = encoder_usage_select[`TLS_ENC_DIGIT_LSB +: 4];
    always_comb begin
        unique case (enc_digit)
            4'h1:    enc_mode_next = tls_pkg::TLS_ENC_INCR;
            4'h2:    enc_mode_next = tls_pkg::TLS_ENC_SINGLE;
            default: enc_mode_next = tls_pkg::tls_enc_mode_t'(enc_fitted);
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            started_reg  <= 1'b0;
            enc_mode_reg <= tls_pkg::TLS_ENC_INCR;
            position_reg <= 32'h0000_0000;
        end else if (!started_reg) begin
            started_reg  <= 1'b1;
            enc_mode_reg <= enc_mode_next;
            // RQ10 absolute modes reload retained position
            position_reg <= (enc_mode_next == tls_pkg::TLS_ENC_INCR) ? 32'h0000_0000 : enc_abs_position;
        end else begin
            position_reg <= position_reg + 32'(enc_delta);
        end
    end
    assign position = position_reg;
    assign enc_mode = enc_mode_reg;
endmodule : tls_top

// file: rtl/tls_map.svh
// register offsets, reset values and field positions of the torque limit select block
// assumes a 32-bit apb slave with one aligned word per register
// Behaviour
// RQ1: forward request active: forward limit is min of forward internal and external setting.
// RQ2: forward request inactive: forward limit is forward internal setting only.
// RQ3: reverse request active: reverse limit is min of reverse internal and named external.
// RQ4: reverse request inactive: reverse limit is reverse internal setting only.
// RQ5: all four limit settings are percent of rated torque, one percent steps.
// RQ6: limited flag is asserted exactly while output torque is being limited.
// RQ7: forward and reverse request terminals chosen by input-assignment digits two and three.
// RQ8: limited flag drives the terminal chosen by output-assignment lowest digit.
// RQ9: encoder usage digit: 0 fitted, 1 incremental, 2 single-turn; applies after restart.
// RQ10: absolute encoder supplies retained position at power-up, no homing needed.
// RQ11: applied torque is further clipped to the attached motor's maximum torque.
// RQ12: request and setting changes take effect on the next control cycle.
`ifndef TLS_MAP_SVH
`define TLS_MAP_SVH
`define TLS_OFS_FWD_INT    8'h00
`define TLS_OFS_REV_INT    8'h04
`define TLS_OFS_FWD_EXT    8'h08
`define TLS_OFS_REV_EXT    8'h0C
`define TLS_OFS_IN_ASSIGN  8'h10
`define TLS_OFS_OUT_ASSIGN 8'h14
`define TLS_OFS_CTRL       8'h18
`define TLS_OFS_STATUS     8'h1C
`define TLS_OFS_INT_STAT   8'h20
`define TLS_OFS_INT_MASK   8'h24
`define TLS_OFS_FWD_ACT    8'h28
`define TLS_OFS_REV_ACT    8'h2C
`define TLS_OFS_POSITION   8'h30
`define TLS_RST_INT_LIMIT  10'h320
`define TLS_RST_EXT_LIMIT  10'h064
`define TLS_RST_IN_ASSIGN  16'h0000
`define TLS_RST_OUT_ASSIGN 16'h0000
`define TLS_FWD_DIGIT_LSB  8
`define TLS_REV_DIGIT_LSB  12
`define TLS_OUT_DIGIT_LSB  0
`define TLS_ENC_DIGIT_LSB  8
`define TLS_IRQ_LIMITED    0
`define TLS_IRQ_FWD_REQ    1
`define TLS_IRQ_REV_REQ    2
`define TLS_IRQ_W          3
`define TLS_CTRL_REV_EXT   0
`endif

// file: rtl/tls_pkg.sv
// types shared by the torque limit select block
// assumes tls_map.svh supplies the numeric constants
package tls_pkg;
    typedef logic [9:0] tls_pct_t;
    typedef enum logic [1:0] {
        TLS_ENC_FOLLOW,
        TLS_ENC_INCR,
        TLS_ENC_SINGLE,
        TLS_ENC_MULTI
    } tls_enc_mode_t;
    typedef struct packed {
        tls_pct_t internal;
        tls_pct_t external;
    } tls_limit_cfg_t;
endpackage : tls_pkg

// file: rtl/tls_term_sel.sv
// picks one input terminal by a four-bit assignment digit
// assumes terminals are already synchronous to the clock
`timescale 1ns/100ps
module tls_term_sel #(
    parameter int N_TERM = 8
) (
    // terminals
    input  wire logic [N_TERM-1:0] term,
    // selection
    input  wire logic [3:0]        digit,
    output logic                   level
);
    // digits past the last terminal mean unassigned, read as open
    assign level = (32'(digit) < N_TERM) ? term[digit[$clog2(N_TERM)-1:0]] : 1'b0;
endmodule : tls_term_sel

// file: rtl/tls_limit_calc.sv
// one direction's active limit and clipping decision
// assumes magnitudes in percent of rated torque
`timescale 1ns/100ps
module tls_limit_calc (
    // settings
    input  wire tls_pkg::tls_limit_cfg_t cfg,
    input  wire tls_pkg::tls_pct_t       motor_max,
    // request and demand
    input  wire logic                    ext_req,
    input  wire logic [10:0]             demand,
    // result
    output tls_pkg::tls_pct_t            limit,
    output logic                         limited
);
    tls_pkg::tls_pct_t sel_limit;
    // RQ1 RQ3 min when requested
    assign sel_limit = (ext_req && cfg.external < cfg.internal) ? cfg.external : cfg.internal;
    // RQ11 motor maximum clip
    assign limit = (motor_max < sel_limit) ? motor_max : sel_limit;
    // RQ6 demand above limit
    assign limited = demand > {1'b0, limit};
endmodule : tls_limit_calc

// file: test/tls_top_monitor.sv
// port checker for the torque limit select block
// assumes one clock, bound to tls_top below
`timescale 1ns/100ps
module tls_top_monitor #(
    parameter int N_OUT = 4
) (
    // clock and reset
    input wire logic                   clock,
    input wire logic                   sys_rst,
    // torque path
    input wire logic [N_OUT-1:0]       out_term,
    input wire logic signed [11:0]     torque_ref,
    input wire tls_pkg::tls_pct_t      motor_max,
    input wire logic signed [11:0]     torque_out,
    input wire logic                   torque_limited_flag,
    // encoder
    input wire logic [15:0]            encoder_usage_select,
    input wire logic [1:0]             enc_fitted,
    input wire logic [31:0]            enc_abs_position,
    input wire logic signed [7:0]      enc_delta,
    input wire logic [31:0]            position,
    input wire tls_pkg::tls_enc_mode_t enc_mode
);
    wire [11:0] mag_out = torque_out[11] ? -torque_out : torque_out;
    wire [11:0] mag_ref = torque_ref[11] ? -torque_ref : torque_ref;
    wire [3:0]  dig     = encoder_usage_select[11:8];
    wire [1:0]  mode_x  = (dig == 4'h1) ? 2'h1 : (dig == 4'h2) ? 2'h2 : enc_fitted;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // start latches once, then accumulation runs
    sequence released;
        $past(sys_rst) && !sys_rst;
    endsequence
    sequence settled;
        !$past(sys_rst, 2);
    endsequence
    out_flag_a: assert property (|out_term |-> torque_limited_flag)
        else $error("terminal set while not limited");
    clip_max_a: assert property (mag_out <= {2'b00, $past(motor_max)})
        else $error("torque above motor maximum");
    pass_thru_a: assert property (!$past(sys_rst) && !torque_limited_flag |-> torque_out == $past(torque_ref))
        else $error("unlimited torque altered");
    clip_less_a: assert property (!$past(sys_rst) && torque_limited_flag |-> mag_out < $past(mag_ref) &&
        (torque_out == 0 || torque_out[11] == $past(torque_ref[11]))) else $error("flag without clipping");
    mode_map_a: assert property (settled |-> enc_mode == mode_x)
        else $error("encoder mode wrong");
    mode_fixed_a: assert property (settled |-> $stable(enc_mode))
        else $error("encoder mode changed without restart");
    start_load_a: assert property (released |=>
        position == ((enc_mode == tls_pkg::TLS_ENC_INCR) ? 32'h0000_0000 : $past(enc_abs_position)))
        else $error("start position wrong");
    pos_accum_a: assert property (settled |->
        position == $past(position) + {{24{$past(enc_delta[7])}}, $past(enc_delta)}) else $error("position drift");
endmodule : tls_top_monitor
bind tls_top tls_top_monitor #(.N_OUT(N_OUT)) tls_top_monitor_inst (.clock(clock), .sys_rst(sys_rst),
    .out_term(out_term), .torque_ref(torque_ref), .motor_max(motor_max), .torque_out(torque_out),
    .torque_limited_flag(torque_limited_flag), .encoder_usage_select(encoder_usage_select),
    .enc_fitted(enc_fitted), .enc_abs_position(enc_abs_position), .enc_delta(enc_delta),
    .position(position), .enc_mode(enc_mode));

// file: test/tls_ctrl_model.sv
// upper controller model driving the limit request terminals
// assumes commands change only after a rising edge
`timescale 1ns/100ps
module tls_ctrl_model (
    // clock
    input  wire logic       clock,
    // commands
    input  wire logic       fwd_on,
    input  wire logic       rev_on,
    input  wire logic [3:0] fwd_pin,
    input  wire logic [3:0] rev_pin,
    // terminals
    output logic [7:0]      in_term
);
    logic [7:0] idle_reg = 8'h55;
    // unused terminals toggle so a wrong routing digit shows
    always @(posedge clock) begin : drive
        logic [7:0] t;
        t = ~idle_reg;
        t[fwd_pin[2:0]] = fwd_on;
        t[rev_pin[2:0]] = rev_on;
        idle_reg <= ~idle_reg;
        in_term  <= t;
    end
endmodule : tls_ctrl_model

// file: test/tb.sv
// self-checking bench for the torque limit select block
// assumes the controller model drives terminals 5 and 2
`timescale 1ns/100ps
`include "tls_map.svh"
module tb;
    logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, flag;
    logic fwd_on = 1'b0, rev_on = 1'b0, e;
    logic [7:0] paddr = 8'h00, in_term;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q, position;
    logic [3:0] out_term;
    logic signed [11:0] torque_ref = 12'sh000, torque_out;
    tls_pkg::tls_pct_t motor_max = 10'h320;
    logic [15:0] enc_sel = 16'h0000;
    logic [1:0] fitted = 2'h3;
    logic signed [7:0] enc_delta = 8'sh00;
    tls_pkg::tls_enc_mode_t enc_mode;
    int miscompares = 0, samples_checked = 0, cyc = 0;
    always #25 clock = ~clock;
    tls_top tls_top_inst (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .in_term(in_term),
        .out_term(out_term), .torque_ref(torque_ref), .motor_max(motor_max), .torque_out(torque_out),
        .torque_limited_flag(flag), .encoder_usage_select(enc_sel), .enc_fitted(fitted),
        .enc_abs_position(32'h0001_2340), .enc_delta(enc_delta), .position(position), .enc_mode(enc_mode),
        .irq(irq));
    tls_ctrl_model tls_ctrl_model_inst (.clock(clock), .fwd_on(fwd_on), .rev_on(rev_on), .fwd_pin(4'h5),
        .rev_pin(4'h2), .in_term(in_term));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, x);
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask : settle
    function automatic logic signed [11:0] mn(input logic [11:0] a, input logic [11:0] b);
        return (a < b) ? a : b;
    endfunction : mn
    task automatic tq(input logic f, input logic r, input logic signed [11:0] t, input logic signed [11:0] x,
                      input logic fl);
        @(posedge clock);
        fwd_on     <= f;
        rev_on     <= r;
        torque_ref <= t;
        settle();
        chk(32'(torque_out), 32'(x));
        chk(32'(flag), 32'(fl));
    endtask : tq
    task automatic do_reset(input logic [3:0] dg);
        sys_rst <= 1'b1;
        enc_sel <= {4'h0, dg, 8'h00};
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
    endtask : do_reset
    task automatic t_regs();
        rd(`TLS_OFS_FWD_INT, 32'h0000_0320);
        rd(`TLS_OFS_REV_INT, 32'h0000_0320);
        rd(`TLS_OFS_FWD_EXT, 32'h0000_0064);
        rd(`TLS_OFS_REV_EXT, 32'h0000_0064);
        rd(8'h40, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        $display("test regs done");
    endtask : t_regs
    task automatic t_fwd();
        apb(1'b1, `TLS_OFS_IN_ASSIGN, 32'h0000_2500);
        apb(1'b1, `TLS_OFS_OUT_ASSIGN, 32'h0000_0003);
        apb(1'b1, `TLS_OFS_FWD_INT, 32'h0000_012C);
        apb(1'b1, `TLS_OFS_FWD_EXT, 32'h0000_0078);
        tq(1'b0, 1'b0, 12'sd500, 12'sd300, 1'b1);
        tq(1'b0, 1'b1, 12'sd500, 12'sd300, 1'b1);
        tq(1'b1, 1'b0, 12'sd500, mn(12'd300, 12'd120), 1'b1);
        chk(32'(out_term), 32'h0000_0008);
        rd(`TLS_OFS_FWD_ACT, 32'h0000_0078);
        rd(`TLS_OFS_STATUS, 32'h0000_003D);
        tq(1'b1, 1'b0, 12'sd100, 12'sd100, 1'b0);
        chk(32'(out_term), 32'h0000_0000);
        apb(1'b1, `TLS_OFS_FWD_EXT, 32'h0000_0190);
        apb(1'b1, `TLS_OFS_OUT_ASSIGN, 32'h0000_0009);
        tq(1'b1, 1'b0, 12'sd500, mn(12'd300, 12'd400), 1'b1);
        chk(32'(out_term), 32'h0000_0000);
        $display("test forward done");
    endtask : t_fwd
    task automatic t_rev();
        apb(1'b1, `TLS_OFS_REV_INT, 32'h0000_00FA);
        apb(1'b1, `TLS_OFS_REV_EXT, 32'h0000_003C);
        apb(1'b1, `TLS_OFS_FWD_EXT, 32'h0000_005A);
        tq(1'b0, 1'b0, -12'sd500, -12'sd250, 1'b1);
        tq(1'b0, 1'b1, -12'sd500, -mn(12'd250, 12'd90), 1'b1);
        tq(1'b1, 1'b0, -12'sd500, -12'sd250, 1'b1);
        apb(1'b1, `TLS_OFS_CTRL, 32'h0000_0001);
        tq(1'b0, 1'b1, -12'sd500, -mn(12'd250, 12'd60), 1'b1);
        $display("test reverse done");
    endtask : t_rev
    task automatic t_max();
        @(posedge clock);
        motor_max <= 10'h032;
        tq(1'b0, 1'b0, 12'sd700, 12'sd50, 1'b1);
        tq(1'b0, 1'b0, -12'sd40, -12'sd40, 1'b0);
        @(posedge clock);
        motor_max <= 10'h320;
        $display("test motor max done");
    endtask : t_max
    task automatic t_irq();
        tq(1'b0, 1'b0, 12'sd0, 12'sd0, 1'b0);
        apb(1'b1, `TLS_OFS_INT_STAT, 32'h0000_0007);
        apb(1'b1, `TLS_OFS_INT_MASK, 32'h0000_0001);
        tq(1'b0, 1'b0, 12'sd500, 12'sd300, 1'b1);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, `TLS_OFS_INT_STAT, 32'h0000_0001);
        #1;
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, `TLS_OFS_INT_MASK, 32'h0000_0000);
        tq(1'b0, 1'b0, 12'sd0, 12'sd0, 1'b0);
        tq(1'b0, 1'b0, 12'sd500, 12'sd300, 1'b1);
        chk(32'(irq), 32'h0000_0000);
        rd(`TLS_OFS_INT_STAT, 32'h0000_0001);
        apb(1'b1, `TLS_OFS_INT_STAT, 32'h0000_0007);
        tq(1'b1, 1'b0, 12'sd0, 12'sd0, 1'b0);
        rd(`TLS_OFS_INT_STAT, 32'h0000_0002);
        $display("test interrupt done");
    endtask : t_irq
    task automatic t_enc();
        tls_pkg::tls_enc_mode_t m;
        // last pass: digit 0 with an incremental encoder fitted
        for (int d = 0; d < 4; d++) begin
            @(posedge clock);
            fitted <= (d == 3) ? 2'h1 : 2'h3;
            do_reset(4'(d % 3));
            settle();
            m = (d == 2) ? tls_pkg::TLS_ENC_SINGLE : (d == 0) ? tls_pkg::TLS_ENC_MULTI : tls_pkg::TLS_ENC_INCR;
            chk(32'(enc_mode), 32'(m));
            chk(position, (m == tls_pkg::TLS_ENC_INCR) ? 32'h0000_0000 : 32'h0001_2340);
            @(posedge clock);
            enc_delta <= 8'sd3;
            repeat (10) @(posedge clock);
            enc_delta <= 8'sd0;
            settle();
            chk(position, (m == tls_pkg::TLS_ENC_INCR) ? 32'h0000_001E : 32'h0001_235E);
        end
        $display("test encoder done");
    endtask : t_enc
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        do_reset(4'h0);
        t_regs();
        t_fwd();
        t_rev();
        t_max();
        t_irq();
        t_enc();
        report_and_stop();
    end
endmodule : tb
